/* core/dbgbp_pkg.sv */
/*
 Constants and types shared by the debug breakpoint status unit and its comparator.
 Assumes a single core clock domain and a flat 32-bit linear address space.
*/
package dbgbp_pkg;
   localparam int DBGBP_NUM_BP = 4;
   localparam int DBGBP_ADDR_W = 32;
   localparam logic [1:0] DBGBP_TYPE_EXEC = 2'h0;
   localparam logic [1:0] DBGBP_TYPE_WRITE = 2'h1;
   localparam logic [1:0] DBGBP_TYPE_IO = 2'h2;
   localparam logic [1:0] DBGBP_TYPE_RDWR = 2'h3;
   localparam logic [31:0] DBGBP_ADDR_RST = 32'h0;
   localparam logic [3:0] DBGBP_FLAGS_RST = 4'h0;
   localparam logic DBGBP_ACCESS_FLAG_RST = 1'b0;
   localparam logic [3:0] DBGBP_PENDING_RST = 4'h0;
   typedef enum logic [1:0] {
      DBGBP_IDLE = 2'b00,
      DBGBP_SHADOW = 2'b01,
      DBGBP_REPEAT = 2'b10
   } dbgbp_state_t;
endpackage : dbgbp_pkg

/* core/dbgbp_match.sv */
/*
 One breakpoint comparator: address equality against the fetch and the data access,
 qualified by the access type field. Purely combinational; the caller registers results.
*/
`timescale 1ns/100ps
module dbgbp_match
   import dbgbp_pkg::*;
(
   input wire logic [DBGBP_ADDR_W-1:0] bp_addr,
   input wire logic [1:0] bp_type,
   input wire logic [DBGBP_ADDR_W-1:0] fetch_addr,
   input wire logic [DBGBP_ADDR_W-1:0] data_addr,
   input wire logic data_valid,
   input wire logic data_write,
   output logic fetch_eq,
   output logic fetch_hit,
   output logic data_hit
);
   always_comb begin
      fetch_eq = (bp_addr == fetch_addr);
      fetch_hit = fetch_eq && (bp_type == DBGBP_TYPE_EXEC);
      data_hit = data_valid && (bp_addr == data_addr) &&
                 ((bp_type == DBGBP_TYPE_RDWR) || (bp_type == DBGBP_TYPE_WRITE && data_write));
   end
endmodule : dbgbp_match

/* core/dbgbp_unit.sv */
/*
 Debug breakpoint status unit: four address registers, enable qualification, status flags
 and the fault/trap pulses, including the reporting quirks around stack-segment loads.
 Assumes one retiring instruction per instr_valid cycle, with its fetch and data access
 presented together, and that all inputs are synchronous to mclk.
*/
`timescale 1ns/100ps
module dbgbp_unit
   import dbgbp_pkg::*;
#(
   parameter int NUM_BP = dbgbp_pkg::DBGBP_NUM_BP
)
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic bp_wr_en,
   input wire logic [1:0] bp_wr_idx,
   input wire logic [dbgbp_pkg::DBGBP_ADDR_W-1:0] bp_wr_data,
   input wire logic [NUM_BP-1:0] local_bp_enables,
   input wire logic [NUM_BP-1:0] global_bp_enables,
   input wire logic [2*NUM_BP-1:0] bp_access_type,
   input wire logic debug_reg_protect_enable,
   input wire logic status_clr,
   input wire logic instr_valid,
   input wire logic [dbgbp_pkg::DBGBP_ADDR_W-1:0] fetch_addr,
   input wire logic fetch_page_fault,
   input wire logic data_valid,
   input wire logic data_write,
   input wire logic [dbgbp_pkg::DBGBP_ADDR_W-1:0] data_addr,
   input wire logic store_split_page,
   input wire logic store_ad_update,
   input wire logic stack_segment_load,
   input wire logic soft_int_instr,
   input wire logic debug_reg_access,
   input wire logic system_management_interrupt,
   output logic [NUM_BP-1:0] breakpoint_match_flags,
   output logic debug_access_flag,
   output logic instr_bp_fault,
   output logic bp_trap,
   output logic debug_access_fault,
   output logic smm_entry
);
   import dbgbp_pkg::*;

   logic [DBGBP_ADDR_W-1:0] bp_addr_reg [NUM_BP];
   logic [NUM_BP-1:0] pending_reg;
   dbgbp_state_t state_reg;
   logic [NUM_BP-1:0] en, other_en, fetch_eq, fetch_hit, data_hit, hit, flag_set;
   logic any_en, pf_spurious, hit_en, data_hit_en, shadow;
   logic take_smm, bd_only, zero_flags, commit, defer, normal, trap_now, twice;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_BP; i++) begin
            bp_addr_reg[i] <= DBGBP_ADDR_RST;
         end
      end else if (bp_wr_en) begin
         bp_addr_reg[bp_wr_idx] <= bp_wr_data;
      end
   end

   for (genvar g = 0; g < NUM_BP; g++) begin : g_bp
      dbgbp_match u_match (
         .bp_addr(bp_addr_reg[g]),
         .bp_type(bp_access_type[2*g +: 2]),
         .fetch_addr(fetch_addr),
         .data_addr(data_addr),
         .data_valid(data_valid),
         .data_write(data_write),
         .fetch_eq(fetch_eq[g]),
         .fetch_hit(fetch_hit[g]),
         .data_hit(data_hit[g])
      );
      assign other_en[g] = |(en & ~(NUM_BP'(1) << g));
   end

   assign en = local_bp_enables | global_bp_enables;
   assign any_en = |en;
   assign hit = fetch_hit | data_hit;
   assign flag_set = hit & (en | other_en);
   assign hit_en = |(hit & en);
   assign data_hit_en = |(data_hit & en);
   // Raw address equality is used on purpose: data-typed disabled registers also trip this.
   assign pf_spurious = fetch_page_fault && any_en && |(~en & fetch_eq);
   assign shadow = (state_reg == DBGBP_SHADOW);

   // Decision for the retiring instruction; the shadow of a stack-segment load takes priority.
   always_comb begin
      take_smm = 1'b0;
      bd_only = 1'b0;
      zero_flags = 1'b0;
      commit = 1'b0;
      defer = 1'b0;
      normal = 1'b0;
      if (instr_valid) begin
         if (shadow) begin
            if (system_management_interrupt) begin
               take_smm = 1'b1;
            end else if (debug_reg_protect_enable && debug_reg_access) begin
               bd_only = 1'b1;
            end else if (soft_int_instr) begin
               zero_flags = 1'b1;
            end else if (store_split_page || store_ad_update) begin
               normal = 1'b1;
            end else begin
               commit = 1'b1;
               normal = 1'b1;
            end
         end else if (system_management_interrupt && data_hit_en) begin
            take_smm = 1'b1;
         end else if (stack_segment_load && data_hit_en) begin
            defer = 1'b1;
         end else begin
            normal = 1'b1;
         end
      end
      trap_now = normal && (hit_en || pf_spurious || (commit && |pending_reg));
      twice = trap_now && debug_reg_access;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= DBGBP_IDLE;
         pending_reg <= DBGBP_PENDING_RST;
      end else if (defer) begin
         state_reg <= DBGBP_SHADOW;
         pending_reg <= flag_set;
      end else if (twice) begin
         state_reg <= DBGBP_REPEAT;
         pending_reg <= DBGBP_PENDING_RST;
      end else if (instr_valid || state_reg == DBGBP_REPEAT) begin
         // Leaving the shadow by any path drops what was pending.
         state_reg <= DBGBP_IDLE;
         pending_reg <= DBGBP_PENDING_RST;
      end
   end

   // A hardware set in the same cycle as a software clear wins.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         breakpoint_match_flags <= DBGBP_FLAGS_RST;
      end else if (zero_flags) begin
         breakpoint_match_flags <= DBGBP_FLAGS_RST;
      end else begin
         breakpoint_match_flags <= (normal ? flag_set : DBGBP_FLAGS_RST) |
                                   (commit ? pending_reg : DBGBP_FLAGS_RST) |
                                   (status_clr ? DBGBP_FLAGS_RST : breakpoint_match_flags);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         debug_access_flag <= DBGBP_ACCESS_FLAG_RST;
      end else if ((normal || bd_only) && debug_reg_protect_enable && debug_reg_access) begin
         debug_access_flag <= 1'b1;
      end else if (status_clr) begin
         debug_access_flag <= DBGBP_ACCESS_FLAG_RST;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         instr_bp_fault <= 1'b0;
         bp_trap <= 1'b0;
         debug_access_fault <= 1'b0;
         smm_entry <= 1'b0;
      end else begin
         instr_bp_fault <= normal && (|(fetch_hit & en) || pf_spurious);
         bp_trap <= trap_now || (state_reg == DBGBP_REPEAT);
         debug_access_fault <= (normal || bd_only) && debug_reg_protect_enable &&
                               debug_reg_access;
         smm_entry <= instr_valid && system_management_interrupt;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   enable_fault_a: assert property (
      (instr_valid && !shadow && !system_management_interrupt && !stack_segment_load &&
       fetch_hit[0] && local_bp_enables[0]) |=> instr_bp_fault)
      else $error("enabled execution breakpoint did not fault");

   disabled_quiet_a: assert property (
      (instr_valid && !fetch_page_fault && !(|(fetch_hit & en))) |=> !instr_bp_fault)
      else $error("fault raised without an enabled execution hit");

   pf_spurious_a: assert property (
      (instr_valid && !shadow && !system_management_interrupt && fetch_page_fault &&
       !stack_segment_load && local_bp_enables[0] && !en[1] && fetch_eq[1]) |=>
       instr_bp_fault && bp_trap)
      else $error("disabled address hit on faulting fetch did not fault");

   bd_only_a: assert property (
      bd_only |=> debug_access_flag && debug_access_fault && !bp_trap)
      else $error("protected access in shadow did not report access flag only");

   discard_a: assert property (
      (shadow && instr_valid && store_split_page && !system_management_interrupt &&
       !debug_reg_access && !soft_int_instr && !hit_en && !pf_spurious) |=> !bp_trap)
      else $error("pending breakpoint survived a page-crossing store");

   zero_flags_a: assert property (
      zero_flags |=> breakpoint_match_flags == DBGBP_FLAGS_RST)
      else $error("interrupt instruction in shadow left match flags set");

   smm_drop_a: assert property (
      (take_smm && state_reg != DBGBP_REPEAT) |=> smm_entry && !bp_trap &&
       pending_reg == DBGBP_PENDING_RST && state_reg == DBGBP_IDLE)
      else $error("breakpoint reported alongside management interrupt entry");

   twice_a: assert property (
      twice |=> bp_trap ##1 bp_trap)
      else $error("debug register breakpoint not reported twice");

   lone_disabled_a: assert property (
      (instr_valid && !shadow && hit[0] && !en[0] && !other_en[0] &&
       !breakpoint_match_flags[0]) |=> !breakpoint_match_flags[0])
      else $error("lone disabled breakpoint set its match flag");

   shadow_commit_c: cover property (defer ##[1:4] commit);
   shadow_zero_c: cover property (defer ##[1:4] zero_flags);
   repeat_c: cover property (twice ##1 state_reg == DBGBP_REPEAT);
   pf_spurious_c: cover property (instr_valid && pf_spurious && normal);
endmodule : dbgbp_unit

/* test/tb_dbgbp_unit.sv */
/*
 Self-checking bench for the debug breakpoint status unit, with a small reference model.
 Assumes the unit's own assertions are compiled in and a single 10 MHz core clock.
*/
`timescale 1ns/100ps
module tb_dbgbp_unit;
   import dbgbp_pkg::*;
   logic mclk, sys_rst, wen, fpf, iv, dv, dw, prot, clr;
   logic [1:0] widx;
   logic [31:0] wd, fa, da;
   logic [3:0] le, ge, fl, mf;
   logic [7:0] ty;
   logic [5:0] att;
   logic daf, ibf, trp, dfl, system_management_handler_mode;
   logic [31:0] a [4];
   logic [8:0] e;
   int errors, comparisons, seed, k, v;
   wire [8:0] o = {fl, daf, ibf, trp, dfl, system_management_handler_mode};
   localparam logic [31:0] NA = 32'hFFFFFFF0;
   localparam logic [5:0] VAR [6] = '{6'h01, 6'h02, 6'h04, 6'h20, 6'h10, 6'h00};
   dbgbp_unit #(.NUM_BP(4)) dbgbp_unit_i (.mclk(mclk), .sys_rst(sys_rst), .bp_wr_en(wen),
      .bp_wr_idx(widx), .bp_wr_data(wd), .local_bp_enables(le), .global_bp_enables(ge),
      .bp_access_type(ty), .debug_reg_protect_enable(prot), .status_clr(clr),
      .instr_valid(iv), .fetch_addr(fa), .fetch_page_fault(fpf), .data_valid(dv),
      .data_write(dw), .data_addr(da), .store_split_page(att[5]), .store_ad_update(att[4]),
      .stack_segment_load(att[3]), .soft_int_instr(att[2]), .debug_reg_access(att[1]),
      .system_management_interrupt(att[0]), .breakpoint_match_flags(fl),
      .debug_access_flag(daf), .instr_bp_fault(ibf), .bp_trap(trp),
      .debug_access_fault(dfl), .smm_entry(system_management_handler_mode));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task chk(input logic [8:0] s, input logic [8:0] x);
      comparisons++;
      if (s !== x) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask : chk
   task give_verdict;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // Reference outcome of one ordinary instruction; updates the sticky flag model.
   function automatic logic [8:0] mdl(input logic [31:0] f, d, input logic p, w);
      logic [3:0] eq, fh, h, en;
      logic pf;
      for (int i = 0; i < 4; i++) begin
         eq[i] = f == a[i];
         fh[i] = eq[i] && ty[2*i+:2] == 2'h0;
         h[i] = fh[i] || (d == a[i] && (ty[2*i+:2] == 2'h3 || (ty[2*i+:2] == 2'h1 && w)));
      end
      en = le | ge;
      // A spurious fetch fault is a reported breakpoint, so it traps as well.
      pf = p && |en && |(eq & ~en);
      mf = mf | ((|en) ? h : 4'h0);
      return {mf, 1'b0, |(fh & en) || pf, |(h & en) || pf, 2'b00};
   endfunction : mdl
   task ins(input logic [31:0] f, d, input logic p, w, input logic [5:0] at,
      input logic [8:0] x, m);
      @(posedge mclk);
      fa <= f; da <= d; fpf <= p; dv <= 1'b1; dw <= w; att <= at; iv <= 1'b1;
      @(posedge mclk);
      iv <= 1'b0; att <= 6'h00;
      #1 chk(o & m, x & m);
   endtask : ins
   task clrf;
      @(posedge mclk) clr <= 1'b1;
      @(posedge mclk) clr <= 1'b0;
      mf = 4'h0;
      #1 chk(o, 9'h000);
   endtask : clrf
   initial begin
      #2000000;
      errors++;
      give_verdict();
   end
   initial begin
      {wen, fpf, iv, dv, dw, prot, clr, widx, wd, fa, da, le, ge, att, mf} = '0;
      ty = 8'hB4; // Types 00, 01, 11 and 10 on breakpoints 0 to 3.
      seed = 75; errors = 0; comparisons = 0; sys_rst = 1'b1;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      for (k = 0; k < 4; k++) begin
         a[k] = $random(seed);
         a[k][1:0] = k[1:0];
         @(posedge mclk) {wen, widx, wd} <= {1'b1, k[1:0], a[k]};
         @(posedge mclk) wen <= 1'b0;
      end
      for (k = 0; k < 8; k++) begin
         clrf();
         le = (k < 4) ? 4'h1 << k : 4'h0;
         ge = (k < 4) ? 4'h0 : 4'h1 << (k - 4);
         e = mdl(a[k%4], a[k%4], 1'b0, 1'b1);
         ins(a[k%4], a[k%4], 1'b0, 1'b1, 6'h00, e, 9'h1FF);
      end
      clrf(); le = 4'h0; ge = 4'h0;
      e = mdl(a[0], NA, 1'b0, 1'b0);
      ins(a[0], NA, 1'b0, 1'b0, 6'h00, e, 9'h1FF);
      le = 4'h2;
      e = mdl(a[0], NA, 1'b0, 1'b0);
      ins(a[0], NA, 1'b0, 1'b0, 6'h00, e, 9'h1FF);
      e = mdl(a[2], NA, 1'b1, 1'b0);
      ins(a[2], NA, 1'b1, 1'b0, 6'h00, e, 9'h1FF);
      // Clearing the disabled register first removes the spurious fault.
      @(posedge mclk) {wen, widx, wd} <= {1'b1, 2'h2, 32'h0};
      @(posedge mclk) wen <= 1'b0;
      v = a[2];
      a[2] = 32'h0;
      e = mdl(v, NA, 1'b1, 1'b0);
      ins(v, NA, 1'b1, 1'b0, 6'h00, e, 9'h1FF);
      clrf(); le = 4'h1;
      e = mdl(a[0], NA, 1'b0, 1'b0);
      ins(a[0], NA, 1'b0, 1'b0, 6'h02, e, 9'h1FF);
      @(posedge mclk);
      #1 chk(o, {mf, 5'b00100});
      le = 4'h2;
      ins(NA, a[1], 1'b0, 1'b1, 6'h01, {mf, 5'b00001}, 9'h1FF);
      for (v = 0; v < 6; v++) begin
         clrf(); le = 4'h3; prot = 1'b1;
         e = mdl(a[0], NA, 1'b0, 1'b0);
         ins(a[0], NA, 1'b0, 1'b0, 6'h00, e, 9'h1FF);
         ins(NA, a[1], 1'b0, 1'b1, 6'h08, {mf, 5'b00000}, 9'h1FF);
         case (v)
            0: e = {mf, 5'b00001};
            1: e = {mf, 5'b10010};
            2: e = 9'h000;
            5: e = {mf | 4'h2, 5'b00100};
            default: e = {mf, 5'b00000};
         endcase
         ins(NA, NA, 1'b0, 1'b0, VAR[v], e, 9'h1FF);
         prot = 1'b0;
      end
      give_verdict();
   end
endmodule : tb_dbgbp_unit
